// File: design/rmvs_pkg.sv
package rmvs_pkg;
	localparam int NUM_REG = 8;
	localparam int NUM_PIN = 4;
	localparam int SYNC_STAGES = 2;
	localparam logic [7:0] ZERO_MAP = 8'h00;
	localparam logic [7:0] ALL_OFF_MAP = 8'hFF;
	// one regulator's resolved state
	typedef enum logic [1:0] {RMVS_OFF, RMVS_ON, RMVS_ECO} rmvs_mode_t;
	// device state for the sleep decision
	typedef enum logic {RMVS_ACTIVE, RMVS_SLEEP} rmvs_state_t;
	// power-up strap capture sequence
	typedef enum logic [1:0] {RMVS_CFG_IDLE, RMVS_CFG_SAMPLE, RMVS_CFG_RUN} rmvs_cfg_t;
endpackage : rmvs_pkg

// File: design/rmvs_sync_if.sv
`timescale 1ns/100ps
interface rmvs_sync_if;
	logic [6:0] raw;
	logic [6:0] synced;
	modport src (output raw, input synced);
	modport dst (input raw, output synced);
endinterface : rmvs_sync_if

// File: design/rmvs_sync.sv
`timescale 1ns/100ps
module rmvs_sync
	import rmvs_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	rmvs_sync_if.dst sif // raw pins in, synced levels out
);
	logic [6:0] stage1;
	logic [6:0] stage2;
	logic [6:0] next_stage1;
	logic [6:0] next_stage2;

	always_comb begin
		next_stage1 = sif.raw;
		next_stage2 = stage1;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			stage1 <= 7'h00;
			stage2 <= 7'h00;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign sif.synced = stage2;
endmodule : rmvs_sync

// File: design/rmvs_top.sv
`timescale 1ns/100ps
module rmvs_top
	import rmvs_pkg::*;
(
	input wire logic clk, // 50 MHz system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic config_state, // device is in CONFIG state
	input wire logic pin_function_strap, // 1: enable pins, 0: select/request pins
	input wire logic otp_bank_strap, // OTP bank choice level
	input wire logic [3:0] res_enable_pin, // enable pins, or voltage-select pins
	input wire logic power_request_pin, // request pin for the first set
	input wire logic clock_request_pin_a, // request pin for the second set
	input wire logic clock_request_pin_b, // request pin for the third set
	input wire logic sleep_pin, // raw sleep input
	input wire logic sleep_pin_allow, // sleep pin enable bit
	input wire logic sleep_pin_polarity, // 1: sleep pin active high
	input wire logic irq_pending, // some unmasked interrupt pending
	input wire logic [7:0] assign_set0, // regulators on first pin
	input wire logic [7:0] assign_set1, // regulators on second pin
	input wire logic [7:0] assign_set2, // regulators on third pin
	input wire logic [7:0] assign_set3, // regulators on fourth pin
	input wire logic [7:0] sleep_keep_on, // keep regulator on in sleep
	input wire logic [7:0] sleep_off_sel, // switch regulator off in sleep
	input wire logic [7:0] sleep_volt_sel, // sleep voltage choice
	input wire logic [7:0] active_volt_sel, // voltage choice when active
	input wire logic [7:0] voltage_select_pin_map, // select pin for each of regulators 4 to 7, two bits each
	output logic [7:0] reg_on, // regulator enabled, full mode
	output logic [7:0] reg_eco, // regulator in low power mode
	output logic [7:0] reg_off, // regulator off
	output logic [7:0] reg_alt_volt, // 1: alternate, 0: primary setting
	output logic otp_bank_sel, // latched bank choice
	output logic otp_copy_pulse, // copy chosen bank to user registers
	output logic device_sleep // device in SLEEP state
);
	import rmvs_pkg::*;

	rmvs_sync_if sif ();
	// pins through the shared synchroniser; fourth enable pin handled below
	assign sif.raw = {sleep_pin, clock_request_pin_b, clock_request_pin_a,
		power_request_pin, res_enable_pin[2:0]};

	rmvs_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.sif(sif)
	);

	// fourth enable pin synchronised on its own
	logic en4_s1;
	logic en4_s2;
	logic next_en4_s1;
	logic next_en4_s2;

	// decode of one regulator's slot in a voltage-select pin map
	function automatic logic [1:0] rmvs_map_pin(input logic [7:0] map, input int idx);
		logic [1:0] res;
		res = 2'h0;
		// four bucks on their own pin; linear regulators pick from map
		if (idx < NUM_PIN) begin
			res = idx[1:0];
		end else begin
			res = map[(idx - NUM_PIN) * 2 +: 2];
		end
		return res;
	endfunction : rmvs_map_pin

	logic [3:0] en_pins;
	logic [2:0] req_pins;
	logic sleep_lvl;
	always_comb begin
		en_pins = {en4_s2, sif.synced[2:0]};
		req_pins = sif.synced[5:3];
		sleep_lvl = sif.synced[6];
	end

	// strap capture
	rmvs_cfg_t cfg_state;
	rmvs_cfg_t next_cfg_state;
	logic bank;
	logic next_bank;
	logic copy;
	logic next_copy;

	always_comb begin
		next_cfg_state = cfg_state;
		next_bank = bank;
		next_copy = 1'b0;
		case (cfg_state)
			RMVS_CFG_IDLE: begin
				if (config_state) begin
					next_cfg_state = RMVS_CFG_SAMPLE;
				end
			end
			RMVS_CFG_SAMPLE: begin
				next_bank = otp_bank_strap;
				next_copy = 1'b1;
				next_cfg_state = RMVS_CFG_RUN;
			end
			RMVS_CFG_RUN: begin
				if (config_state) begin
					next_cfg_state = RMVS_CFG_SAMPLE;
				end
			end
			default: begin
				next_cfg_state = RMVS_CFG_IDLE;
			end
		endcase
	end

	// sleep pin reads active, and sleep is allowed at all
	logic sleep_asserted;
	logic sleep_allowed;
	always_comb begin
		sleep_asserted = (sleep_lvl == sleep_pin_polarity);
		sleep_allowed = sleep_pin_allow && !irq_pending;
	end

	// device sleep state
	rmvs_state_t dev_state;
	rmvs_state_t next_dev_state;
	always_comb begin
		next_dev_state = dev_state;
		// sleep pin exists only with the strap high
		if (!pin_function_strap) begin
			next_dev_state = RMVS_ACTIVE;
		end else if (sleep_allowed) begin
			next_dev_state = sleep_asserted ? RMVS_SLEEP : RMVS_ACTIVE;
		end else begin
			next_dev_state = RMVS_ACTIVE;
		end
	end

	// per-regulator resolution
	logic [7:0] next_on;
	logic [7:0] next_eco;
	logic [7:0] next_off;
	logic [7:0] next_alt;
	logic [7:0] assigned;
	logic [7:0] pin_high;
	logic [7:0] sel_pin;
	logic [7:0] in_low;

	// mode of a regulator whose pin, or the device, reads low
	function automatic rmvs_mode_t rmvs_low_mode(input logic keep_on, input logic off_sel);
		rmvs_mode_t res;
		res = RMVS_ECO;
		if (keep_on) begin
			res = RMVS_ON;
		end else if (off_sel) begin
			res = RMVS_OFF;
		end else begin
			res = RMVS_ECO;
		end
		return res;
	endfunction : rmvs_low_mode

	genvar gi;
	generate
		// which pins a regulator listens to, and whether it reads low
		for (gi = 0; gi < NUM_REG; gi++) begin : g_pin
			always_comb begin
				sel_pin[gi] = en_pins[rmvs_map_pin(voltage_select_pin_map, gi)];
				if (pin_function_strap) begin
					assigned[gi] = assign_set0[gi] | assign_set1[gi]
						| assign_set2[gi] | assign_set3[gi];
					pin_high[gi] = (assign_set0[gi] & en_pins[0])
						| (assign_set1[gi] & en_pins[1])
						| (assign_set2[gi] & en_pins[2])
						| (assign_set3[gi] & en_pins[3]);
				end else begin
					// fourth set unused here; software keeps it zero
					assigned[gi] = assign_set0[gi] | assign_set1[gi] | assign_set2[gi];
					pin_high[gi] = (assign_set0[gi] & req_pins[0])
						| (assign_set1[gi] & req_pins[1])
						| (assign_set2[gi] & req_pins[2]);
				end
				if (assigned[gi]) begin
					in_low[gi] = !pin_high[gi];
				end else begin
					in_low[gi] = (dev_state == RMVS_SLEEP);
				end
			end
		end

		// mode from the low flag and the sleep bits; voltage from the select pin, or with the strap high from the low flag
		for (gi = 0; gi < NUM_REG; gi++) begin : g_reg
			always_comb begin
				rmvs_mode_t mode;
				mode = RMVS_ON;
				if (!in_low[gi]) begin
					mode = RMVS_ON;
				end else begin
					mode = rmvs_low_mode(sleep_keep_on[gi], sleep_off_sel[gi]);
				end
				next_on[gi] = (mode == RMVS_ON);
				next_eco[gi] = (mode == RMVS_ECO);
				next_off[gi] = (mode == RMVS_OFF);
				if (!pin_function_strap) begin
					next_alt[gi] = sel_pin[gi];
				end else if (in_low[gi]) begin
					next_alt[gi] = sleep_volt_sel[gi];
				end else begin
					next_alt[gi] = active_volt_sel[gi];
				end
			end
		end
	endgenerate

	// fourth enable pin: same two-stage synchroniser as the others
	always_comb begin
		next_en4_s1 = res_enable_pin[3];
		next_en4_s2 = en4_s1;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			en4_s1 <= 1'b0;
			en4_s2 <= 1'b0;
		end else begin
			en4_s1 <= next_en4_s1;
			en4_s2 <= next_en4_s2;
		end
	end

	// strap capture registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg_state <= RMVS_CFG_IDLE;
			bank <= 1'b0;
			copy <= 1'b0;
		end else begin
			cfg_state <= next_cfg_state;
			bank <= next_bank;
			copy <= next_copy;
		end
	end

	// device state register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dev_state <= RMVS_ACTIVE;
		end else begin
			dev_state <= next_dev_state;
		end
	end

	// status outputs, each taken straight from a flip-flop
	logic next_bank_sel;
	logic next_copy_pulse;
	logic next_sleep_out;
	always_comb begin
		next_bank_sel = bank;
		next_copy_pulse = copy;
		next_sleep_out = (dev_state == RMVS_SLEEP);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			otp_bank_sel <= 1'b0;
			otp_copy_pulse <= 1'b0;
			device_sleep <= 1'b0;
		end else begin
			otp_bank_sel <= next_bank_sel;
			otp_copy_pulse <= next_copy_pulse;
			device_sleep <= next_sleep_out;
		end
	end

	// resolved regulator outputs; all off while in reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_on <= ZERO_MAP;
			reg_eco <= ZERO_MAP;
			reg_off <= ALL_OFF_MAP;
			reg_alt_volt <= ZERO_MAP;
		end else begin
			reg_on <= next_on;
			reg_eco <= next_eco;
			reg_off <= next_off;
			reg_alt_volt <= next_alt;
		end
	end
endmodule : rmvs_top

// File: dv/rmvs_host.sv
`timescale 1ns/100ps
module rmvs_host (
	input wire logic clk, // clock
	output logic [3:0] res_enable_pin, // enable or select pins
	output logic power_request_pin, // request a
	output logic clock_request_pin_a, // request b
	output logic clock_request_pin_b, // request c
	output logic sleep_pin // raw sleep
);
	initial begin
		{res_enable_pin, power_request_pin, clock_request_pin_a} = '0;
		{clock_request_pin_b, sleep_pin} = '0;
	end
	// pins move only at the falling edge, away from sampling
	task automatic drive(input logic [7:0] v);
		@(negedge clk);
		{res_enable_pin, power_request_pin, clock_request_pin_a, clock_request_pin_b,
			sleep_pin} = v;
	endtask : drive
endmodule : rmvs_host

// File: dv/rmvs_chk.sv
`timescale 1ns/100ps
module rmvs_chk (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic config_state, // watched
	input wire logic pin_function_strap, // watched
	input wire logic sleep_pin_allow, // watched
	input wire logic irq_pending, // watched
	input wire logic [7:0] sleep_keep_on, // watched
	input wire logic [7:0] sleep_off_sel, // watched
	input wire logic [7:0] reg_on, // watched
	input wire logic [7:0] reg_eco, // watched
	input wire logic [7:0] reg_off, // watched
	input wire logic otp_bank_sel, // watched
	input wire logic otp_copy_pulse, // watched
	input wire logic device_sleep // watched
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_mode_onehot: assert property ((reg_on | reg_eco | reg_off) == 8'hFF &&
		((reg_on & reg_eco) | (reg_off & (reg_on | reg_eco))) == 8'h00) else $error("mode not one-hot");
	a_keep_on: assert property ($past(rstn) |->
		(reg_on & $past(sleep_keep_on)) == $past(sleep_keep_on)) else $error("kept regulator not on");
	a_off_cause: assert property ($past(rstn) |->
		(reg_off & ~($past(sleep_off_sel) & ~$past(sleep_keep_on))) == 8'h00) else $error("bad off");
	a_eco_cause: assert property ($past(rstn) |->
		(reg_eco & ($past(sleep_off_sel) | $past(sleep_keep_on))) == 8'h00) else $error("bad eco");
	a_copy_once: assert property (otp_copy_pulse |=>
		!otp_copy_pulse) else $error("long copy");
	a_bank_hold: assert property (!config_state [*6] |->
		$stable(otp_bank_sel)) else $error("bank moved");
	a_sleep_refuse: assert property ((irq_pending || !sleep_pin_allow) [*5] |->
		!device_sleep) else $error("sleep not refused");
	a_strap_awake: assert property (!pin_function_strap [*5] |->
		!device_sleep) else $error("sleep on strap low");
	c_sleep: cover property (device_sleep);
	c_eco: cover property (reg_eco != 8'h00);
	c_copy: cover property (otp_copy_pulse);
endmodule : rmvs_chk
bind rmvs_top rmvs_chk u_chk (.clk, .rstn, .config_state, .pin_function_strap, .sleep_pin_allow,
	.irq_pending, .sleep_keep_on, .sleep_off_sel, .reg_on, .reg_eco, .reg_off, .otp_bank_sel,
	.otp_copy_pulse, .device_sleep);

// File: dv/regulator_mode_voltage_select_tb_top.sv
`timescale 1ns/100ps
module regulator_mode_voltage_select_tb_top;
	import rmvs_pkg::*;
	logic clk = 1'h0, rstn = 1'h0, config_state = 1'h0, pin_function_strap = 1'h0;
	logic otp_bank_strap = 1'h0, sleep_pin_allow = 1'h0;
	logic sleep_pin_polarity = 1'h0, irq_pending = 1'h0;
	logic [7:0] assign_set0 = '0, assign_set1 = '0, assign_set2 = '0, assign_set3 = '0;
	logic [7:0] sleep_keep_on = '0, sleep_off_sel = '0, sleep_volt_sel = '0, active_volt_sel = '0;
	logic [7:0] voltage_select_pin_map = '0, reg_on, reg_eco, reg_off, reg_alt_volt;
	logic [7:0] e_on, e_eco, e_off, e_alt;
	logic [3:0] res_enable_pin, st, pn;
	logic power_request_pin, clock_request_pin_a, clock_request_pin_b, sleep_pin;
	logic otp_bank_sel, otp_copy_pulse, device_sleep, slp, low;
	int bad_count = 0, checks_done = 0, seed = 80, copies = 0;
	rmvs_host u_host (.clk, .res_enable_pin, .power_request_pin, .clock_request_pin_a,
		.clock_request_pin_b, .sleep_pin);
	rmvs_top u_dut (.*);
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic model;
		slp = pin_function_strap & sleep_pin_allow & !irq_pending
			& (sleep_pin == sleep_pin_polarity);
		pn = pin_function_strap ? res_enable_pin
			: {1'h0, clock_request_pin_b, clock_request_pin_a, power_request_pin};
		for (int i = 0; i < NUM_REG; i++) begin
			st = {assign_set3[i], assign_set2[i], assign_set1[i], assign_set0[i]};
			low = (|st) ? !(|(st & pn)) : slp;
			e_on[i] = !low | sleep_keep_on[i];
			e_off[i] = low & !sleep_keep_on[i] & sleep_off_sel[i];
			e_eco[i] = low & !sleep_keep_on[i] & !sleep_off_sel[i];
			e_alt[i] = low ? sleep_volt_sel[i] : active_volt_sel[i];
			if (!pin_function_strap) e_alt[i] = res_enable_pin[i < 4 ? i
				: int'(voltage_select_pin_map[2*(i-4)+:2])];
		end
	endtask : model
	initial begin
		forever #10 clk = ~clk;
	end
	// one copy pulse is expected per entry into the config state
	always @(negedge clk) begin
		if (otp_copy_pulse === 1'h1) copies++;
	end
	initial begin
		#100000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(negedge clk);
		chk("reg_off", reg_off, 8'hFF);
		rstn = 1'h1;
		for (int t = 0; t < 300; t++) begin
			u_host.drive(8'($random(seed)));
			pin_function_strap = 1'($random(seed));
			{sleep_pin_allow, sleep_pin_polarity, irq_pending, otp_bank_strap} = 4'($random(seed));
			{assign_set0, assign_set1, assign_set2} = 24'($random(seed) & $random(seed));
			assign_set3 = pin_function_strap ? 8'($random(seed) & $random(seed)) : 8'h00;
			{sleep_keep_on, sleep_off_sel, sleep_volt_sel, active_volt_sel} = $random(seed);
			voltage_select_pin_map = 8'($random(seed));
			config_state = 1'h1;
			repeat (7) @(negedge clk) config_state = 1'h0;
			model();
			chk("reg_on", reg_on, e_on);
			chk("reg_eco", reg_eco, e_eco);
			chk("reg_off", reg_off, e_off);
			chk("reg_alt_volt", reg_alt_volt & ~e_off, e_alt & ~e_off);
			chk("device_sleep", {7'h00, device_sleep}, {7'h00, slp});
			chk("otp_bank_sel", {7'h00, otp_bank_sel}, {7'h00, otp_bank_strap});
			chk("otp_copy_pulse", 8'(copies), 8'(t + 1));
		end
		tally_and_finish();
	end
endmodule : regulator_mode_voltage_select_tb_top
